//--- hw/bie_map.svh
// constants and operation summary for the branch and increment execution block
// Operation
// - An opcode whose top three bits are 101 is the absolute branch, and its low eleven bits are the target.
// - The absolute branch loads its eleven-bit target into program counter bits 10 to 0.
// - The absolute branch fills program counter bits 12 and 11 from page latch bits 4 and 3.
// - The absolute branch takes two instruction cycles and changes no status flag.
// - Opcode 00 1111 with a destination bit and 7-bit address is increment-skip-if-zero, which changes no flag.
// - For both increments a destination bit of 0 writes the working register and 1 writes the file register.
// - When increment-skip-if-zero yields zero, the prefetched next instruction is discarded.
// - A discarded instruction becomes a no-operation cycle, so the skip takes one cycle, or two when it skips.
// - Opcode 00 1010 with a destination bit and 7-bit address is the plain increment of the addressed register.
`ifndef BIE_MAP_SVH
`define BIE_MAP_SVH
`define BIE_BRANCH_TOP 3'h5
`define BIE_BRANCH_TOP_MSB 13
`define BIE_BRANCH_TOP_LSB 11
`define BIE_TARGET_MSB 10
`define BIE_OPC_MSB 13
`define BIE_OPC_LSB 8
`define BIE_OPC_INC_SKIP 6'h0f
`define BIE_OPC_INC 6'h0a
`define BIE_DEST_BIT 7
`define BIE_ADDR_MSB 6
`define BIE_PAGE_MSB 4
`define BIE_PAGE_LSB 3
`define BIE_PC_RESET 13'h0000
`define BIE_ADDR_RESET 7'h00
`define BIE_BYTE_RESET 8'h00
`define BIE_FLAG_RESET 1'h0
`define BIE_BRANCH_CYCLES 2'h2
`endif

//--- hw/bie_pkg.sv
// types for the branch and increment execution block
package bie_pkg;
    typedef logic [13:0] bie_word_t;
    typedef logic [12:0] bie_pc_t;
    typedef logic [7:0] bie_byte_t;
    typedef enum logic [1:0] {
        BIE_OP_OTHER = 2'h0,
        BIE_OP_BRANCH = 2'h1,
        BIE_OP_INC_SKIP = 2'h2,
        BIE_OP_INC = 2'h3
    } bie_op_e;
endpackage : bie_pkg

//--- hw/bie_dec_if.sv
// decoded instruction fields passed from decoder to executor
`timescale 1ns/100ps
interface bie_dec_if;
    import bie_pkg::*;
    bie_op_e op;
    logic dest_file;
    logic [6:0] addr;
    logic [10:0] target;
    modport dec (output op, output dest_file, output addr, output target);
    modport exe (input op, input dest_file, input addr, input target);
endinterface : bie_dec_if

//--- hw/bie_decoder.sv
// combinational instruction decoder
`timescale 1ns/100ps
`include "bie_map.svh"
module bie_decoder (
    input wire bie_pkg::bie_word_t instr,
    bie_dec_if.dec dec
);
    import bie_pkg::*;
    always_comb begin
        dec.op = BIE_OP_OTHER;
        if (instr[`BIE_BRANCH_TOP_MSB:`BIE_BRANCH_TOP_LSB] == `BIE_BRANCH_TOP) begin
            dec.op = BIE_OP_BRANCH;
        end else if (instr[`BIE_OPC_MSB:`BIE_OPC_LSB] == `BIE_OPC_INC_SKIP) begin
            dec.op = BIE_OP_INC_SKIP;
        end else if (instr[`BIE_OPC_MSB:`BIE_OPC_LSB] == `BIE_OPC_INC) begin
            dec.op = BIE_OP_INC;
        end
    end
    assign dec.dest_file = instr[`BIE_DEST_BIT];
    assign dec.addr = instr[`BIE_ADDR_MSB:0];
    assign dec.target = instr[`BIE_TARGET_MSB:0];
endmodule : bie_decoder

//--- hw/bie_exec.sv
// branch and increment execution unit, one instruction cycle per enabled clock
`timescale 1ns/100ps
`include "bie_map.svh"
module bie_exec (
    input wire logic clock,
    input wire logic srst,
    input wire logic cycle_en,
    input wire bie_pkg::bie_word_t instr,
    input wire bie_pkg::bie_byte_t page_latch,
    input wire bie_pkg::bie_byte_t file_rdata,
    input wire logic zero_in,
    output logic [6:0] file_addr,
    output logic file_we,
    output bie_pkg::bie_byte_t file_wdata,
    output logic work_we,
    output bie_pkg::bie_byte_t work_wdata,
    output logic zero_we,
    output logic zero_out,
    output bie_pkg::bie_pc_t pc,
    output logic nop_cycle,
    output logic busy
);
    import bie_pkg::*;

    // run executes the word on instr, slot retires a discarded word
    typedef enum logic {
        BIE_PH_RUN = 1'h0,
        BIE_PH_SLOT = 1'h1
    } bie_phase_e;

    typedef struct packed {
        bie_pc_t pc;
        bie_phase_e phase;
        logic [6:0] file_addr;
        logic file_we;
        bie_byte_t file_wdata;
        logic work_we;
        bie_byte_t work_wdata;
        logic zero_we;
        logic zero_out;
        logic nop_cycle;
    } bie_state_s;

    bie_state_s st_q;
    bie_state_s st_d;
    bie_byte_t sum;
    logic sum_zero;
    logic exec_live;
    logic slot_live;
    logic is_branch;
    logic is_inc_skip;
    logic is_inc;
    logic is_inc_any;
    logic skip_taken;
    logic to_file;
    logic to_work;
    logic [1:0] page_bits;
    logic [10:0] target_bits;
    bie_pc_t seq_pc;
    bie_pc_t branch_pc;
    bie_pc_t next_pc;
    bie_phase_e next_phase;

    bie_dec_if dec_bus ();

    bie_decoder u_dec (
        .instr(instr),
        .dec(dec_bus.dec)
    );

    // one shared incrementer, wrapping at the byte boundary
    assign sum = file_rdata + 8'h01;
    assign sum_zero = (sum == 8'h00);

    // an enabled edge in run executes instr, one in slot retires it unseen
    assign exec_live = cycle_en & (st_q.phase == BIE_PH_RUN);
    assign slot_live = cycle_en & (st_q.phase == BIE_PH_SLOT);

    assign is_branch = exec_live & (dec_bus.op == BIE_OP_BRANCH);
    assign is_inc_skip = exec_live & (dec_bus.op == BIE_OP_INC_SKIP);
    assign is_inc = exec_live & (dec_bus.op == BIE_OP_INC);
    assign is_inc_any = is_inc_skip | is_inc;

    // destination select shared by both increment forms
    assign to_file = is_inc_any & dec_bus.dest_file;
    assign to_work = is_inc_any & ~dec_bus.dest_file;

    // zero result of the skip form discards the prefetched word
    assign skip_taken = is_inc_skip & sum_zero;

    // branch target: page bits on top of the eleven-bit immediate
    assign page_bits = page_latch[`BIE_PAGE_MSB:`BIE_PAGE_LSB];
    assign target_bits = dec_bus.target;
    assign branch_pc = {page_bits, target_bits};
    assign seq_pc = st_q.pc + 13'h0001;
    assign next_pc = is_branch ? branch_pc : seq_pc;

    // branch always, skip form on zero, spend a second cycle in slot
    assign next_phase = (is_branch | skip_taken) ? BIE_PH_SLOT : BIE_PH_RUN;

    always_comb begin
        st_d = st_q;
        if (cycle_en) begin
            // strobes last from one enabled edge to the next
            st_d.file_we = 1'b0;
            st_d.work_we = 1'b0;
            st_d.zero_we = 1'b0;
            st_d.nop_cycle = 1'b0;
            st_d.file_addr = dec_bus.addr;
            st_d.pc = next_pc;
            st_d.phase = next_phase;
            case (st_q.phase)
                BIE_PH_SLOT: begin
                    // discarded prefetch slot runs as no-operation
                    st_d.nop_cycle = slot_live;
                end
                BIE_PH_RUN: begin
                    case (dec_bus.op)
                        BIE_OP_BRANCH: begin
                            // no flag moves during either branch cycle
                            st_d.zero_out = st_q.zero_out;
                        end
                        BIE_OP_INC_SKIP: begin
                            st_d.file_we = to_file;
                            st_d.work_we = to_work;
                            st_d.file_wdata = sum;
                            st_d.work_wdata = sum;
                            st_d.zero_out = st_q.zero_out;
                        end
                        BIE_OP_INC: begin
                            st_d.file_we = to_file;
                            st_d.work_we = to_work;
                            st_d.file_wdata = sum;
                            st_d.work_wdata = sum;
                            st_d.zero_we = is_inc;
                            st_d.zero_out = sum_zero;
                        end
                        default: begin
                            st_d.zero_out = zero_in;
                        end
                    endcase
                end
                default: begin
                    st_d.phase = BIE_PH_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_q.pc <= `BIE_PC_RESET;
            st_q.phase <= BIE_PH_RUN;
            st_q.file_addr <= `BIE_ADDR_RESET;
            st_q.file_we <= `BIE_FLAG_RESET;
            st_q.file_wdata <= `BIE_BYTE_RESET;
            st_q.work_we <= `BIE_FLAG_RESET;
            st_q.work_wdata <= `BIE_BYTE_RESET;
            st_q.zero_we <= `BIE_FLAG_RESET;
            st_q.zero_out <= `BIE_FLAG_RESET;
            st_q.nop_cycle <= `BIE_FLAG_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign file_addr = st_q.file_addr;
    assign file_we = st_q.file_we;
    assign file_wdata = st_q.file_wdata;
    assign work_we = st_q.work_we;
    assign work_wdata = st_q.work_wdata;
    assign zero_we = st_q.zero_we;
    assign zero_out = st_q.zero_out;
    assign pc = st_q.pc;
    assign nop_cycle = st_q.nop_cycle;
    assign busy = st_q.phase;
endmodule : bie_exec

//--- tb/bie_exec_chk.sv
// port assertions for the execution block
`timescale 1ns/100ps
module bie_exec_chk (
    input wire logic clock,
    input wire logic srst,
    input wire logic cycle_en,
    input wire bie_pkg::bie_word_t instr,
    input wire bie_pkg::bie_byte_t page_latch,
    input wire bie_pkg::bie_byte_t file_rdata,
    input wire logic zero_in,
    input wire logic [6:0] file_addr,
    input wire logic file_we,
    input wire bie_pkg::bie_byte_t file_wdata,
    input wire logic work_we,
    input wire bie_pkg::bie_byte_t work_wdata,
    input wire logic zero_we,
    input wire logic zero_out,
    input wire bie_pkg::bie_pc_t pc,
    input wire logic nop_cycle,
    input wire logic busy
);
    import bie_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    wire go = cycle_en && !busy;
    wire br = go && instr[13:11] == 3'h5;
    wire inc = go && instr[13:8] == 6'h0a;
    wire skp = go && instr[13:8] == 6'h0f;
    wire wrap = file_rdata == 8'hff;
    wire dst = instr[7];
    wire [6:0] adr = instr[6:0];
    wire [7:0] sum = file_rdata + 8'h1;
    wire [12:0] tgt = {page_latch[4:3], instr[10:0]};
    sequence slot_s; busy ##1 (nop_cycle && !busy); endsequence
    br_target_a: assert property (br |=> pc == $past(tgt) && !zero_we)
        else $error("pc");
    br_slot_a: assert property (br |=> slot_s) else $error("slot");
    nop_slot_a: assert property (busy && cycle_en |=> nop_cycle && !file_we && !work_we)
        else $error("nop");
    skip_take_a: assert property (skp && wrap |=> slot_s) else $error("skip");
    skip_flag_a: assert property (skp |=> !zero_we && busy == $past(wrap))
        else $error("flag");
    inc_zero_a: assert property (inc |=> zero_we && zero_out == $past(wrap) && !busy)
        else $error("zero");
    inc_dest_a: assert property (inc || skp |=> file_we == $past(dst) && work_we != file_we)
        else $error("dest");
    inc_value_a: assert property (inc || skp |=> (file_we ? file_wdata : work_wdata) ==
        $past(sum) && (!file_we || file_addr == $past(adr))) else $error("value");
endmodule : bie_exec_chk

//--- tb/tb_branch_increment_exec.sv
// self-checking bench for the branch and increment execution block
`timescale 1ns/100ps
module tb_branch_increment_exec;
    import bie_pkg::*;
    logic clock = 0, srst = 1, cycle_en = 1, zero_in = 0, busy_m = 0;
    logic file_we, work_we, zero_we, zero_out, nop_cycle, busy;
    bie_word_t instr = 0;
    bie_byte_t page_latch = 0, file_rdata = 0, file_wdata, work_wdata;
    logic [6:0] file_addr;
    bie_pc_t pc, pc_m = 0;
    logic [33:0] q[$], obs, last_exp = 0;
    logic [31:0] k;
    int seed = 43, num_errors = 0, comparisons = 0, cycles = 0;
    bie_exec uut (.*);
    always #5 clock = ~clock;
    task stop_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    task step(input bie_word_t i, input bie_byte_t r);
        logic [7:0] s;
        logic t;
        k = $random(seed);
        if (!busy_m && k[12:10] == 3'h0) begin
            cycle_en = 0;
            q.push_back(last_exp);
            @(negedge clock);
            cycle_en = 1;
        end
        instr = i;
        file_rdata = r;
        page_latch = k[7:0];
        zero_in = k[8];
        s = r + 8'h1;
        t = i[13:8] == 6'h0a;
        pc_m = pc_m + 13'h1;
        if (busy_m) begin
            busy_m = 0;
            q.push_back({pc_m, 6'h04, 15'h0});
        end else if (i[13:11] == 3'h5) begin
            pc_m = {page_latch[4:3], i[10:0]};
            busy_m = 1;
            q.push_back({pc_m, 6'h02, 15'h0});
        end else if (t || i[13:8] == 6'h0f) begin
            busy_m = !t && s == 0;
            q.push_back({pc_m, i[7], !i[7], t, 1'b0, busy_m, t && s == 0, i[7] ? i[6:0] : 7'h0, s});
        end else q.push_back({pc_m, 21'h0});
        last_exp = q[$];
        @(negedge clock);
    endtask : step
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            num_errors++;
            stop_test;
        end
        #1;
        if (q.size() > 0 && !srst) begin
            obs = {pc, file_we, work_we, zero_we, nop_cycle, busy, zero_we & zero_out,
                file_we ? file_addr : 7'h0, file_we ? file_wdata : work_we ? work_wdata : 8'h0};
            comparisons++;
            if (q[0] !== obs) begin
                num_errors++;
                $display("ERROR outputs exp %h got %h", q[0], obs);
            end
            void'(q.pop_front());
        end
    end
    initial begin
        repeat (6) @(negedge clock);
        srst = 0;
        step(14'h0f85, 8'hff);
        step(14'h2abc, 8'h12);
        step(14'h0a05, 8'hff);
        repeat (300) begin
            k = $random(seed);
            step(k[1] ? (k[0] ? {6'h38, k[9:2]} : {3'h5, k[12:2]}) : {k[0] ? 6'h0f : 6'h0a, k[9:2]},
                k[10] ? 8'hff : k[18:11]);
        end
        @(negedge clock);
        stop_test;
    end
endmodule : tb_branch_increment_exec
bind bie_exec bie_exec_chk chk (.*);
